/* scg_defines.vh */
/*
 * register map, field positions, reset values and masks of the sleep-mode clock gate block.
 * assumes a 32-bit AXI4-Lite register bus and one system clock domain.
 */
`ifndef SCG_DEFINES_VH
`define SCG_DEFINES_VH

// ****************************************************************
// register byte offsets within the system control region
// ****************************************************************
`define SCG_BASE_ADDR 32'h400F_E000
`define SCG_OFF_RUN_GATE 12'h0_104
`define SCG_OFF_SLEEP_GATE 12'h0_114
`define SCG_OFF_DEEP_GATE 12'h0_124
`define SCG_OFF_RUN_CFG 12'h0_060
`define SCG_OFF_POWER_STATE 12'h0_200

// ****************************************************************
// field positions
// ****************************************************************
`define SCG_BIT_CMP1 25
`define SCG_BIT_CMP0 24
`define SCG_BIT_TMR3 19
`define SCG_BIT_TMR2 18
`define SCG_BIT_TMR1 17
`define SCG_BIT_TMR0 16
`define SCG_BIT_TW1 14
`define SCG_BIT_TW0 12
`define SCG_BIT_SS1 5
`define SCG_BIT_SS0 4
`define SCG_BIT_AS2 2
`define SCG_BIT_AS1 1
`define SCG_BIT_AS0 0
`define SCG_BIT_AUTO_GATE 27

// ****************************************************************
// writable masks and reset values
// ****************************************************************
`define SCG_GATE_MASK 32'h030F_5037
`define SCG_CFG_MASK 32'h0800_0000
`define SCG_GATE_RESET 32'h0000_0000
`define SCG_CFG_RESET 32'h0000_0000

// power states
`define SCG_PWR_RUN 2'h0
`define SCG_PWR_SLEEP 2'h1
`define SCG_PWR_DEEP 2'h2

// axi response codes
`define SCG_RESP_OKAY 2'h0
`define SCG_RESP_SLVERR 2'h2

`endif

/* scg_gate_cell.v */
/*
 * one glitch-free clock gate cell: enable latched while the clock is low.
 * assumes a free-running source clock; the enable comes from the same clock domain.
 */
`timescale 1ns/100ps

module scg_gate_cell (
    input wire clk,
    input wire rst,
    input wire enable,
    output wire gated_clk
);

    reg enable_low;

    // capture the enable on the falling edge so the gate can only open or close while clk is low
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            enable_low <= 1'b0;
        end else begin
            enable_low <= enable;
        end
    end

    assign gated_clk = clk & enable_low;

endmodule

/* scg_sleep_gate.v */
/*
 * sleep-mode clock gating control with its run and deep-sleep siblings, the auto gating
 * select, per-unit clock gates and the unclocked-unit bus fault decision.
 * assumes an AXI4-Lite master on clk, a power state input from the power manager on the
 * same clock, and that each peripheral bus decoder reports which unit an access targets.
 */
`timescale 1ns/100ps
`include "scg_defines.vh"

// Summary of operation
// R1: set bit clocks unit, clear stops it
// R2: access to unclocked unit returns bus fault
// R3: sleep gate register resets to zero
// R4: sleep gate register decoded at 0x114
// R5: run, sleep, deep registers follow power state
// R6: sleep sets used only with auto gating
// R7: bits 25,24 gate analog comparators 1,0
// R8: bits 19..16 gate timers 3..0
// R9: bits 14,12 gate two-wire modules 1,0
// R10: bits 5,4 gate synchronous serial 1,0
// R11: reserved bits read zero, read-only
// R12: software enables the units it needs
// R13: bits 2..0 gate async serial 2..0
// R14: writes to reserved bits are ignored
module scg_sleep_gate (
    input wire clk,
    input wire rst,
    // axi4-lite slave
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // power state from the power manager
    input wire [1:0] power_state,
    // peripheral access check: one-hot unit select in the gate bit layout
    input wire periph_access,
    input wire [31:0] periph_unit_sel,
    output reg periph_fault,
    // effective enables and gated clocks
    output reg [31:0] unit_clk_en,
    output wire analog_comparator_one_gate,
    output wire analog_comparator_zero_gate,
    output wire gp_timer_3_gate,
    output wire gp_timer_2_gate,
    output wire gp_timer_1_gate,
    output wire gp_timer_0_gate,
    output wire twowire_1_gate,
    output wire twowire_0_gate,
    output wire sync_serial_1_gate,
    output wire sync_serial_0_gate,
    output wire async_serial_2_gate,
    output wire async_serial_1_gate,
    output wire async_serial_0_gate
);

    // ****************************************************************
    // state
    // ****************************************************************
    localparam ST_IDLE = 3'b001;
    localparam ST_RESP = 3'b010;
    localparam ST_HOLD = 3'b100;

    reg [31:0] run_clock_gate_1;
    reg [31:0] sleep_clock_gate_1;
    reg [31:0] deep_sleep_clock_gate_1;
    reg [31:0] run_clock_configuration;
    reg [2:0] wr_state;
    reg aw_held;
    reg w_held;
    reg [11:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [31:0] next_unit_clk_en;
    reg [31:0] rd_value;
    reg rd_hit;

    wire aw_take;
    wire w_take;
    wire ar_take;
    wire do_write;
    wire [11:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire auto_gating;
    wire [9:0] wr_word;

    // ****************************************************************
    // helper functions
    // ****************************************************************

    // word index of a byte offset; the byte-lane bits are left to the strobes
    function [9:0] word_of;
        input [11:0] offs;
        begin
            word_of = offs[11:2];
        end
    endfunction

    // merge byte lanes of a write, then keep only writable bits
    function [31:0] merge_write;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] strb;
        input [31:0] mask;
        reg [31:0] lanes;
        begin
            lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
            merge_write = ((old_val & ~lanes) | (new_val & lanes)) & mask;
        end
    endfunction

    // true when the word address names a mapped register
    function is_mapped;
        input [11:0] addr;
        begin
            is_mapped = (word_of(addr) == word_of(`SCG_OFF_RUN_GATE)) ||
                (word_of(addr) == word_of(`SCG_OFF_SLEEP_GATE)) ||
                (word_of(addr) == word_of(`SCG_OFF_DEEP_GATE)) ||
                (word_of(addr) == word_of(`SCG_OFF_RUN_CFG)) ||
                (word_of(addr) == word_of(`SCG_OFF_POWER_STATE));
        end
    endfunction

    // ****************************************************************
    // write channel
    // ****************************************************************

    // address and data are accepted independently, in either order, then held until the response
    assign s_axi_awready = wr_state[0] & ~aw_held;
    assign s_axi_wready = wr_state[0] & ~w_held;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign do_write = wr_state[0] & (aw_held | aw_take) & (w_held | w_take);
    assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    assign wr_data = w_held ? w_data : s_axi_wdata;
    assign wr_strb = w_held ? w_strb : s_axi_wstrb;
    // one decode of the write word, shared by every register below
    assign wr_word = word_of(wr_addr);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_state <= ST_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h0_000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SCG_RESP_OKAY;
        end else begin
            case (wr_state)
                ST_IDLE: begin
                    if (do_write) begin
                        aw_held <= 1'b0;
                        w_held <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= is_mapped(wr_addr) ? `SCG_RESP_OKAY : `SCG_RESP_SLVERR;
                        wr_state <= ST_RESP;
                    end else begin
                        if (aw_take) begin
                            aw_held <= 1'b1;
                            aw_addr <= s_axi_awaddr;
                        end
                        if (w_take) begin
                            w_held <= 1'b1;
                            w_data <= s_axi_wdata;
                            w_strb <= s_axi_wstrb;
                        end
                    end
                end
                ST_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wr_state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // one idle cycle keeps channel ready low right after a response
                    wr_state <= ST_IDLE;
                end
                default: begin
                    wr_state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************

    // reserved positions are masked off on every write, so they stay zero
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            run_clock_gate_1 <= `SCG_GATE_RESET;
            sleep_clock_gate_1 <= `SCG_GATE_RESET; // R3
            deep_sleep_clock_gate_1 <= `SCG_GATE_RESET;
            run_clock_configuration <= `SCG_CFG_RESET;
        end else if (do_write) begin
            if (wr_word == word_of(`SCG_OFF_RUN_GATE)) begin
                run_clock_gate_1 <= merge_write(run_clock_gate_1, wr_data, wr_strb, `SCG_GATE_MASK);
            end
            if (wr_word == word_of(`SCG_OFF_SLEEP_GATE)) begin // R4
                sleep_clock_gate_1 <= merge_write(sleep_clock_gate_1, wr_data, wr_strb, `SCG_GATE_MASK); // R14
            end
            if (wr_word == word_of(`SCG_OFF_DEEP_GATE)) begin
                deep_sleep_clock_gate_1 <= merge_write(deep_sleep_clock_gate_1, wr_data, wr_strb, `SCG_GATE_MASK);
            end
            if (wr_word == word_of(`SCG_OFF_RUN_CFG)) begin
                run_clock_configuration <= merge_write(run_clock_configuration, wr_data, wr_strb, `SCG_CFG_MASK);
            end
        end
    end

    // ****************************************************************
    // read channel
    // ****************************************************************
    assign s_axi_arready = ~s_axi_rvalid;
    assign ar_take = s_axi_arvalid & s_axi_arready;

    // reserved bits are never stored, so they read back as zero
    always @* begin
        rd_hit = 1'b1;
        rd_value = 32'h0000_0000;
        case (s_axi_araddr[11:2])
            word_of(`SCG_OFF_RUN_GATE): rd_value = run_clock_gate_1;
            word_of(`SCG_OFF_SLEEP_GATE): rd_value = sleep_clock_gate_1; // R11
            word_of(`SCG_OFF_DEEP_GATE): rd_value = deep_sleep_clock_gate_1;
            word_of(`SCG_OFF_RUN_CFG): rd_value = run_clock_configuration;
            word_of(`SCG_OFF_POWER_STATE): rd_value = {30'h0000_0000, power_state};
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SCG_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_hit ? `SCG_RESP_OKAY : `SCG_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // gate selection by power state
    // ****************************************************************
    assign auto_gating = run_clock_configuration[`SCG_BIT_AUTO_GATE];

    // without auto gating the run set stays in force in every state
    always @* begin
        next_unit_clk_en = run_clock_gate_1; // R5
        if (auto_gating) begin // R6
            case (power_state)
                `SCG_PWR_SLEEP: next_unit_clk_en = sleep_clock_gate_1; // R5
                `SCG_PWR_DEEP: next_unit_clk_en = deep_sleep_clock_gate_1;
                // code 3 names no state, so it falls back to the run set
                default: next_unit_clk_en = run_clock_gate_1;
            endcase
        end
    end

    // registered so the gate cells see a clean, glitch-free enable
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            unit_clk_en <= `SCG_GATE_RESET;
        end else begin
            unit_clk_en <= next_unit_clk_en & `SCG_GATE_MASK;
        end
    end

    // ****************************************************************
    // bus fault for unclocked units
    // ****************************************************************

    // fault whenever the selected unit has no clock; a limitation is that the
    // check uses the enable one cycle old, matching what the gate cell applies
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            periph_fault <= 1'b0;
        end else begin
            periph_fault <= periph_access & ((periph_unit_sel & unit_clk_en) == 32'h0000_0000); // R2
        end
    end

    // ****************************************************************
    // per-unit clock gates
    // ****************************************************************
    wire [12:0] gated;
    wire [12:0] gate_en;

    assign gate_en = {unit_clk_en[`SCG_BIT_CMP1], unit_clk_en[`SCG_BIT_CMP0], // R7
                      unit_clk_en[`SCG_BIT_TMR3], unit_clk_en[`SCG_BIT_TMR2], // R8
                      unit_clk_en[`SCG_BIT_TMR1], unit_clk_en[`SCG_BIT_TMR0],
                      unit_clk_en[`SCG_BIT_TW1], unit_clk_en[`SCG_BIT_TW0], // R9
                      unit_clk_en[`SCG_BIT_SS1], unit_clk_en[`SCG_BIT_SS0], // R10
                      unit_clk_en[`SCG_BIT_AS2], unit_clk_en[`SCG_BIT_AS1], // R13
                      unit_clk_en[`SCG_BIT_AS0]};

    genvar gi;
    generate
        for (gi = 0; gi < 13; gi = gi + 1) begin : g_gate
            scg_gate_cell u_cell (
                .clk(clk),
                .rst(rst),
                .enable(gate_en[gi]), // R1
                .gated_clk(gated[gi])
            );
        end
    endgenerate

    assign analog_comparator_one_gate = gated[12];
    assign analog_comparator_zero_gate = gated[11];
    assign gp_timer_3_gate = gated[10];
    assign gp_timer_2_gate = gated[9];
    assign gp_timer_1_gate = gated[8];
    assign gp_timer_0_gate = gated[7];
    assign twowire_1_gate = gated[6];
    assign twowire_0_gate = gated[5];
    assign sync_serial_1_gate = gated[4];
    assign sync_serial_0_gate = gated[3];
    assign async_serial_2_gate = gated[2];
    assign async_serial_1_gate = gated[1];
    assign async_serial_0_gate = gated[0];

endmodule

/* scg_sleep_gate_assertions.sv */
/*
 * concurrent checks on the sleep-mode clock gate block, bound to its top module.
 * assumes only the top module's ports, one clock and an async active-high reset.
 */
`timescale 1ns/100ps
`include "scg_defines.vh"

module scg_sleep_gate_assertions (
    input wire clk,
    input wire rst,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire periph_access,
    input wire [31:0] periph_unit_sel,
    input wire periph_fault,
    input wire [31:0] unit_clk_en,
    input wire async_serial_0_gate,
    input wire analog_comparator_one_gate
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ****************************************************************
    // enables, faults and gated clocks
    // ****************************************************************
    property p_reserved_low;
        (unit_clk_en & ~`SCG_GATE_MASK) == 32'h0000_0000;
    endproperty
    a_reserved_low: assert property (p_reserved_low) else $error("reserved enable bit set");
    property p_reset_clear;
        $fell(rst) |-> unit_clk_en == 32'h0000_0000 && !periph_fault && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
    property p_fault_off;
        periph_access && (periph_unit_sel & unit_clk_en) == 32'h0000_0000 |=> periph_fault;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("no fault on unclocked unit");
    property p_no_fault_on;
        periph_access && (periph_unit_sel & unit_clk_en) != 32'h0000_0000 |=> !periph_fault;
    endproperty
    a_no_fault_on: assert property (p_no_fault_on) else $error("fault on clocked unit");
    property p_fault_cause;
        !periph_access |=> !periph_fault;
    endproperty
    a_fault_cause: assert property (p_fault_cause) else $error("fault without access");
    // sampled on the falling edge so the high phase of the gated clock is seen
    property p_gate_bit0;
        @(negedge clk) unit_clk_en[0] == $past(unit_clk_en[0]) |-> async_serial_0_gate == unit_clk_en[0];
    endproperty
    a_gate_bit0: assert property (p_gate_bit0) else $error("gated clock 0 disagrees with enable");
    property p_gate_bit25;
        @(negedge clk) unit_clk_en[25] == $past(unit_clk_en[25]) |-> analog_comparator_one_gate == unit_clk_en[25];
    endproperty
    a_gate_bit25: assert property (p_gate_bit25) else $error("gated clock 25 disagrees with enable");
    // ****************************************************************
    // bus responses hold while stalled
    // ****************************************************************
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped while stalled");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data changed while stalled");
endmodule

/* tb_top.sv */
/*
 * self-checking bench for the sleep-mode clock gate block over AXI4-Lite.
 * assumes the block answers within a few cycles; the bench stalls ready one cycle per answer.
 */
`timescale 1ns/100ps
`include "scg_defines.vh"

module tb_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    reg [31:0] s_axi_wdata = 32'h0000_0000, periph_unit_sel = 32'h0000_0000;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg [1:0] power_state = 2'h0;
    reg periph_access = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, periph_fault;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, unit_clk_en;
    wire analog_comparator_one_gate, analog_comparator_zero_gate, gp_timer_3_gate, gp_timer_2_gate;
    wire gp_timer_1_gate, gp_timer_0_gate, twowire_1_gate, twowire_0_gate, sync_serial_1_gate;
    wire sync_serial_0_gate, async_serial_2_gate, async_serial_1_gate, async_serial_0_gate;
    integer fail_count = 0, tests_run = 0, i;
    int bit_tab[13] = '{25, 24, 19, 18, 17, 16, 14, 12, 5, 4, 2, 1, 0};
    reg [31:0] pw_exp[4];
    // gated clocks gathered back into the gate-bit layout
    wire [31:0] gate_vec = {6'h0, analog_comparator_one_gate, analog_comparator_zero_gate, 4'h0, gp_timer_3_gate,
        gp_timer_2_gate, gp_timer_1_gate, gp_timer_0_gate, 1'b0, twowire_1_gate, 1'b0, twowire_0_gate, 6'h0,
        sync_serial_1_gate, sync_serial_0_gate, 1'b0, async_serial_2_gate, async_serial_1_gate, async_serial_0_gate};

    always #4 clk = ~clk;

    scg_sleep_gate u_scg_sleep_gate (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_state,
        .periph_access, .periph_unit_sel, .periph_fault, .unit_clk_en, .analog_comparator_one_gate,
        .analog_comparator_zero_gate, .gp_timer_3_gate, .gp_timer_2_gate, .gp_timer_1_gate, .gp_timer_0_gate,
        .twowire_1_gate, .twowire_0_gate, .sync_serial_1_gate, .sync_serial_0_gate, .async_serial_2_gate,
        .async_serial_1_gate, .async_serial_0_gate);

    // ****************************************************************
    // reporting
    // ****************************************************************
    task check(input string nm, input [31:0] got, input [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task print_verdict;
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // a wait that used up its bound ends the run
    task give_up(input ok);
        if (!ok) begin
            fail_count = fail_count + 1;
            print_verdict;
        end
    endtask

    // ****************************************************************
    // bus cycles: ready is raised one cycle late to exercise the stall
    // ****************************************************************
    task axi_write(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
        integer n;
        reg done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!done && n < 40) begin
            @(posedge clk);
            n = n + 1;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bready <= 1'b0;
                done = 1'b1;
                check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
            end else if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        give_up(done);
    endtask

    task axi_read(input [11:0] a, input [31:0] ed, input [1:0] er);
        integer n;
        reg done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!done && n < 40) begin
            @(posedge clk);
            n = n + 1;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rready <= 1'b0;
                done = 1'b1;
                check("rdata", s_axi_rdata, ed);
                check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
            end else if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        give_up(done);
    endtask

    // enables follow the power state one edge later; checked after two falling edges
    task set_power(input [1:0] p);
        @(posedge clk);
        power_state <= p;
        repeat (2) @(negedge clk);
    endtask

    task fault_probe(input [31:0] sel, input exp);
        @(posedge clk);
        periph_access <= 1'b1;
        periph_unit_sel <= sel;
        @(posedge clk);
        periph_access <= 1'b0;
        @(negedge clk);
        check("periph_fault", {31'h0, periph_fault}, {31'h0, exp});
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        pw_exp = '{32'h0000_0010, 32'h030f_5000, 32'h0100_0001, 32'h0000_0010};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        axi_read(12'h114, 32'h0000_0000, 2'h0);
        check("en_reset", unit_clk_en, 32'h0000_0000);
        fault_probe(32'h0000_0001, 1'b1);
        axi_write(12'h114, 32'hffff_ffff, 4'hf, 2'h0);
        axi_read(12'h114, 32'h030f_5037, 2'h0);
        axi_write(12'h114, 32'h0000_0000, 4'h1, 2'h0);
        axi_read(12'h114, 32'h030f_5000, 2'h0);
        axi_write(12'h104, 32'h0000_0010, 4'hf, 2'h0);
        axi_write(12'h124, 32'h0100_0001, 4'hf, 2'h0);
        set_power(`SCG_PWR_SLEEP);
        check("en_no_auto", unit_clk_en, 32'h0000_0010);
        axi_write(12'h060, 32'hffff_ffff, 4'hf, 2'h0);
        axi_read(12'h060, 32'h0800_0000, 2'h0);
        for (i = 0; i < 4; i = i + 1) begin
            set_power(i[1:0]);
            check("en_state", unit_clk_en, pw_exp[i]);
            axi_read(12'h200, i, 2'h0);
        end
        set_power(`SCG_PWR_SLEEP);
        // walk one enable through every gate bit, with clock and fault outcome
        for (i = 0; i < 13; i = i + 1) begin
            axi_write(12'h114, 32'h0000_0001 << bit_tab[i], 4'hf, 2'h0);
            set_power(`SCG_PWR_SLEEP);
            check("en_bit", unit_clk_en, 32'h0000_0001 << bit_tab[i]);
            @(posedge clk);
            #2;
            check("gate_clk", gate_vec, 32'h0000_0001 << bit_tab[i]);
            fault_probe(32'h0000_0001 << bit_tab[i], 1'b0);
            fault_probe(32'h0000_0008, 1'b1);
        end
        axi_write(12'h008, 32'hffff_ffff, 4'hf, `SCG_RESP_SLVERR);
        axi_read(12'h008, 32'h0000_0000, `SCG_RESP_SLVERR);
        @(posedge clk);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        axi_read(12'h114, 32'h0000_0000, 2'h0);
        axi_read(12'h060, 32'h0000_0000, 2'h0);
        print_verdict;
    end
endmodule

bind scg_sleep_gate scg_sleep_gate_assertions u_scg_sleep_gate_assertions (.clk, .rst, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .periph_access, .periph_unit_sel, .periph_fault,
    .unit_clk_en, .async_serial_0_gate, .analog_comparator_one_gate);
